/* ddcc_decode.sv */
// Configuration registers and decode of downconverter channel one.
// Assumes synchronous register strobes and sample inputs on sys_clk.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ddcc_defines.svh"
module ddcc_decode #(
    parameter int SAMPLE_W = 14
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`DDCC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] chan_a,
    input wire logic [SAMPLE_W-1:0] chan_b,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic [SAMPLE_W-1:0] path_i,
    output logic [SAMPLE_W-1:0] path_q,
    output logic path_valid,
    input wire logic path_ready,
    output logic mixer_complex,
    output logic gain_double,
    output ddcc_pkg::ddcc_if_mode_t if_mode,
    output logic real_output,
    output logic [8:0] stage_enable,
    output logic [5:0] decim_factor,
    output logic decim_invalid
);
    import ddcc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Stage bits: 0..3 half-band first..fourth, 4 thirdband first,
    // 5 thirdband second, 6 fifthband, 7..8 spare zero.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] insel;
        logic [7:0] rdata;
        logic mixer;
        logic gain;
        logic [1:0] ifm;
        logic c2r;
        logic [8:0] stages;
        logic [5:0] factor;
        logic invalid;
    } ddcc_state_t;

    ddcc_state_t st;
    ddcc_state_t next_st;
    logic [2*SAMPLE_W-1:0] buf_out;
    logic buf_valid;
    logic buf_in_ready;
    logic [2*SAMPLE_W-1:0] sel_pair;
    logic [8:0] dec_stages;
    logic [5:0] dec_real;
    logic dec_bad;

    // ------------------------------------------------------------
    // Filter chain decode
    // ------------------------------------------------------------
    always_comb begin
        dec_stages = 9'h000;
        dec_real = 6'h00;
        dec_bad = 1'b0;
        if (st.ctrl[`DDCC_DEC_HI:`DDCC_DEC_LO] != `DDCC_DEC_EXTENDED) begin
            unique case (st.ctrl[`DDCC_DEC_HI:`DDCC_DEC_LO])
                3'h0: begin dec_stages = 9'h003; dec_real = 6'h02; end
                3'h1: begin dec_stages = 9'h007; dec_real = 6'h04; end
                3'h2: begin dec_stages = 9'h00F; dec_real = 6'h08; end
                3'h3: begin dec_stages = 9'h001; dec_real = 6'h01; end
                3'h4: begin dec_stages = 9'h021; dec_real = 6'h03; end
                3'h5: begin dec_stages = 9'h023; dec_real = 6'h06; end
                default: begin dec_stages = 9'h027; dec_real = 6'h0C; end
            endcase
        end else begin
            // Extended field consulted here and again in the factor select below
            case (st.insel[`DDCC_EXT_HI:`DDCC_EXT_LO])
                4'h0: begin dec_stages = 9'h02F; dec_real = 6'h18; end
                4'h2: begin dec_stages = 9'h041; dec_real = 6'h05; end
                4'h3: begin dec_stages = 9'h043; dec_real = 6'h0A; end
                4'h4: begin dec_stages = 9'h047; dec_real = 6'h14; end
                4'h7: begin dec_stages = 9'h010; dec_real = 6'h00; end
                4'h8: begin dec_stages = 9'h050; dec_real = 6'h00; end
                4'h9: begin dec_stages = 9'h052; dec_real = 6'h00; end
                default: dec_bad = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file and next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (reg_wr && reg_addr == `DDCC_OFF_CONTROL) begin
            next_st.ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == `DDCC_OFF_INSEL) begin
            next_st.insel = reg_wdata & `DDCC_INSEL_WMASK;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `DDCC_OFF_CONTROL: next_st.rdata = st.ctrl;
                `DDCC_OFF_INSEL: next_st.rdata = st.insel & `DDCC_INSEL_WMASK;
                default: next_st.rdata = 8'h00;
            endcase
        end
        next_st.mixer = st.ctrl[`DDCC_BIT_MIXER];
        next_st.gain = st.ctrl[`DDCC_BIT_GAIN];
        next_st.ifm = st.ctrl[`DDCC_IFM_HI:`DDCC_IFM_LO];
        next_st.c2r = st.ctrl[`DDCC_BIT_C2R];
        next_st.stages = dec_stages;
        next_st.invalid = dec_bad
            || (dec_real == 6'h00 && !dec_bad && st.ctrl[`DDCC_BIT_C2R]);
        if (dec_real == 6'h00) begin
            // First third-band chains: complex factor is 3, 15 or 30
            unique case (st.insel[`DDCC_EXT_HI:`DDCC_EXT_LO])
                4'h7: next_st.factor = 6'h03;
                4'h8: next_st.factor = 6'h0F;
                4'h9: next_st.factor = 6'h1E;
                default: next_st.factor = 6'h00;
            endcase
        end else if (st.ctrl[`DDCC_BIT_C2R]) begin
            next_st.factor = dec_real;
        end else begin
            next_st.factor = {dec_real[4:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= `DDCC_RST_CONTROL;
            st.insel <= `DDCC_RST_INSEL;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Channel routing and buffer
    // ------------------------------------------------------------
    assign sel_pair[2*SAMPLE_W-1:SAMPLE_W] = st.insel[`DDCC_BIT_ISEL] ? chan_b : chan_a;
    assign sel_pair[SAMPLE_W-1:0] = st.insel[`DDCC_BIT_QSEL] ? chan_b : chan_a;

    ddcc_skid #(
        .WIDTH(2*SAMPLE_W)
    ) u_skid (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(sel_pair),
        .in_valid(sample_valid),
        .in_ready(buf_in_ready),
        .out_data(buf_out),
        .out_valid(buf_valid),
        .out_ready(path_ready)
    );

    assign sample_ready = buf_in_ready;
    assign path_i = buf_out[2*SAMPLE_W-1:SAMPLE_W];
    assign path_q = buf_out[SAMPLE_W-1:0];
    assign path_valid = buf_valid;
    assign reg_rdata = st.rdata;
    assign mixer_complex = st.mixer;
    assign gain_double = st.gain;
    assign if_mode = ddcc_if_mode_t'(st.ifm);
    assign real_output = st.c2r;
    assign stage_enable = st.stages;
    assign decim_factor = st.factor;
    assign decim_invalid = st.invalid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mixer;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `DDCC_OFF_CONTROL ##2 !$past(reg_wr)
            |-> mixer_complex == $past(reg_wdata[`DDCC_BIT_MIXER], 2);
    endproperty
    a_mixer: assert property (p_mixer) else $error("mixer select wrong");

    property p_gain;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `DDCC_OFF_CONTROL ##2 !$past(reg_wr)
            |-> gain_double == $past(reg_wdata[`DDCC_BIT_GAIN], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain select wrong");

    property p_ifm;
        @(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> if_mode == ddcc_if_mode_t'($past(st.ctrl[5:4]));
    endproperty
    a_ifm: assert property (p_ifm) else $error("if mode wrong");

    property p_c2r;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[2:0] == 3'h2 |=>
            decim_factor == ($past(st.ctrl[3]) ? 6'h08 : 6'h10);
    endproperty
    a_c2r: assert property (p_c2r) else $error("factor for code 2 wrong");

    property p_tb2;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[2:0] == 3'h6 |=> stage_enable == 9'h027;
    endproperty
    a_tb2: assert property (p_tb2) else $error("third-band chain wrong");

    property p_ext_ignored;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[2:0] != 3'h7 |=> !decim_invalid;
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) else $error("extended leak");

    property p_ext48;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[3:0] == 4'h7 && st.insel[7:4] == 4'h0
            |=> decim_factor == 6'h30;
    endproperty
    a_ext48: assert property (p_ext48) else $error("decimate 48 wrong");

    property p_ext40;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[3:0] == 4'h7 && st.insel[7:4] == 4'h4
            |=> decim_factor == 6'h28;
    endproperty
    a_ext40: assert property (p_ext40) else $error("decimate 40 wrong");

    property p_ext30;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[2:0] == 3'h7 && st.insel[7:4] == 4'h9
            |=> decim_factor == 6'h1E;
    endproperty
    a_ext30: assert property (p_ext30) else $error("decimate 30 wrong");

    property p_rsvd;
        @(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == `DDCC_OFF_INSEL |=> !reg_rdata[`DDCC_BIT_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_route;
        @(posedge sys_clk) disable iff (rst)
        sample_valid && sample_ready && path_valid && !path_ready
            && $stable(st.insel) |=> path_valid;
    endproperty
    a_route: assert property (p_route) else $error("buffered word lost");

    property p_route_i;
        @(posedge sys_clk) disable iff (rst)
        sample_valid && sample_ready && !path_valid && st.insel[0]
            |=> path_i == $past(chan_b);
    endproperty
    a_route_i: assert property (p_route_i) else $error("I path not from channel B");

    property p_route_q;
        @(posedge sys_clk) disable iff (rst)
        sample_valid && sample_ready && !path_valid && !st.insel[2]
            |=> path_q == $past(chan_a);
    endproperty
    a_route_q: assert property (p_route_q) else $error("Q path not from channel A");

    property p_hb1_only;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[2:0] == 3'h3 |=> stage_enable == 9'h001;
    endproperty
    a_hb1_only: assert property (p_hb1_only) else $error("single half-band wrong");

    property p_fifth10;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[3:0] == 4'h7 && st.insel[7:4] == 4'h2
            |=> decim_factor == 6'h0A && stage_enable == 9'h041;
    endproperty
    a_fifth10: assert property (p_fifth10) else $error("decimate 10 wrong");

    property p_third_real;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[3:0] == 4'hC |=> decim_factor == 6'h03;
    endproperty
    a_third_real: assert property (p_third_real) else $error("real decimate 3 wrong");

    property p_half_real;
        @(posedge sys_clk) disable iff (rst)
        st.ctrl[3:0] == 4'hF && st.insel[7:4] == 4'h8
            |=> decim_invalid && decim_factor == 6'h0F;
    endproperty
    a_half_real: assert property (p_half_real) else $error("half-rate real accepted");

    c_ext: cover property (@(posedge sys_clk) st.ctrl[2:0] == 3'h7 && decim_invalid);
    c_stall: cover property (@(posedge sys_clk) !sample_ready);
    c_read: cover property (@(posedge sys_clk) reg_rd ##1 reg_rdata != 8'h00);
    c_real_ok: cover property (@(posedge sys_clk) real_output && !decim_invalid);
    c_pop: cover property (@(posedge sys_clk) path_valid && path_ready && !sample_ready);
endmodule : ddcc_decode

/* ddcc_defines.svh */
// Constants for the downconverter channel one configuration decode.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DDCC_DEFINES_SVH
`define DDCC_DEFINES_SVH
`define DDCC_ADDR_W 12
`define DDCC_OFF_CONTROL 12'h330
`define DDCC_OFF_INSEL 12'h331
`define DDCC_RST_CONTROL 8'h00
`define DDCC_RST_INSEL 8'h05
`define DDCC_BIT_MIXER 7
`define DDCC_BIT_GAIN 6
`define DDCC_IFM_HI 5
`define DDCC_IFM_LO 4
`define DDCC_BIT_C2R 3
`define DDCC_DEC_HI 2
`define DDCC_DEC_LO 0
`define DDCC_EXT_HI 7
`define DDCC_EXT_LO 4
`define DDCC_BIT_QSEL 2
`define DDCC_BIT_RSVD 3
`define DDCC_BIT_ISEL 0
`define DDCC_INSEL_WMASK 8'hF5
`define DDCC_DEC_EXTENDED 3'h7
`define DDCC_BUF_DEPTH 2
`endif

/* ddcc_pkg.sv */
// Types for the downconverter channel one configuration decode.
// Assumes the defines header sits in the same folder.
`include "ddcc_defines.svh"
package ddcc_pkg;
    typedef enum logic [1:0] {
        DDCC_IF_VARIABLE = 2'h0,
        DDCC_IF_ZERO = 2'h1,
        DDCC_IF_QUARTER = 2'h2,
        DDCC_IF_TEST = 2'h3
    } ddcc_if_mode_t;
endpackage : ddcc_pkg

/* ddcc_skid.sv */
// Two-entry valid/ready buffer for the selected sample pair.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module ddcc_skid #(
    parameter int WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [WIDTH-1:0] d0;
        logic [WIDTH-1:0] d1;
        logic [1:0] cnt;
    } ddcc_skid_state_t;

    ddcc_skid_state_t st;
    ddcc_skid_state_t next_st;
    logic push;
    logic pop;

    assign in_ready = (st.cnt != 2'h2);
    assign out_valid = (st.cnt != 2'h0);
    assign out_data = st.d0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.d0 = st.d1;
        end
        if (push) begin
            if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
                next_st.d0 = in_data;
            end else begin
                next_st.d1 = in_data;
            end
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ddcc_skid

/* ddcc_sample_src.sv */
// Model of converter channels A and B feeding the sample handshake.
// Assumes one clock with the design; run starts traffic, slow adds random gaps.
`timescale 1ns/1ps
module ddcc_sample_src #(
    parameter int SAMPLE_W = 14
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic slow,
    input wire logic sample_ready,
    output logic [SAMPLE_W-1:0] chan_a,
    output logic [SAMPLE_W-1:0] chan_b,
    output logic sample_valid
);
    // Hold each word until taken; while idle the data toggles so stale values never match
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sample_valid <= 1'b0;
            chan_a <= '0;
            chan_b <= '1;
        end else if (!sample_valid || sample_ready) begin
            if (run && (!slow || $urandom_range(3) == 0)) begin
                sample_valid <= 1'b1;
                chan_a <= SAMPLE_W'($urandom);
                chan_b <= SAMPLE_W'($urandom);
            end else begin
                sample_valid <= 1'b0;
                chan_a <= ~chan_a;
                chan_b <= ~chan_b;
            end
        end
    end
endmodule : ddcc_sample_src

/* test_ddcc_decode.sv */
// Self-checking bench for the channel one configuration decode.
// Assumes the sample source model and the design files are compiled first.
`timescale 1ns/1ps
module test_ddcc_decode;
    import ddcc_pkg::*;
    localparam int SW = 14;
    // Key 0..6 primary codes, 8..23 extended codes 0..15
    localparam int ST_TAB[24] = '{3, 7, 15, 1, 33, 35, 39, 0, 47, 0, 65, 67, 71, 0, 0, 16,
        80, 82, 0, 0, 0, 0, 0, 0};
    localparam int FC_TAB[24] = '{4, 8, 16, 2, 6, 12, 24, 0, 48, 0, 10, 20, 40, 0, 0, 3,
        15, 30, 0, 0, 0, 0, 0, 0};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic path_ready = 1'b0;
    logic run = 1'b1;
    logic slow = 1'b1;
    logic stall = 1'b0;
    logic [7:0] reg_rdata;
    logic [SW-1:0] chan_a, chan_b, path_i, path_q;
    logic sample_valid, sample_ready, path_valid, mixer_complex, gain_double, real_output;
    ddcc_if_mode_t if_mode;
    logic [8:0] stage_enable;
    logic [5:0] decim_factor;
    logic decim_invalid;
    logic [7:0] sh_insel = 8'h05;
    logic [2*SW-1:0] q[$];
    int bad_count = 0;
    int compares = 0;

    always #2 sys_clk = ~sys_clk;

    ddcc_decode #(.SAMPLE_W(SW)) ddcc_decode_i (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan_a(chan_a), .chan_b(chan_b),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .path_i(path_i),
        .path_q(path_q), .path_valid(path_valid), .path_ready(path_ready),
        .mixer_complex(mixer_complex), .gain_double(gain_double), .if_mode(if_mode),
        .real_output(real_output), .stage_enable(stage_enable),
        .decim_factor(decim_factor), .decim_invalid(decim_invalid));
    ddcc_sample_src #(.SAMPLE_W(SW)) ddcc_sample_src_i (.sys_clk(sys_clk), .rst(rst),
        .run(run), .slow(slow), .sample_ready(sample_ready), .chan_a(chan_a),
        .chan_b(chan_b), .sample_valid(sample_valid));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask : rd

    // ----------------------------------------
    // Stream scoreboard, routing by input select at the accepting edge
    // ----------------------------------------
    always @(posedge sys_clk) path_ready <= !stall && ($urandom_range(3) != 0);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh_insel = 8'h05;
            q.delete();
        end else begin
            if (path_valid && path_ready) begin
                check("path_iq", {path_i, path_q}, q.size() > 0 ? q.pop_front() : 'x);
            end
            if (sample_valid && sample_ready) begin
                q.push_back({sh_insel[0] ? chan_b : chan_a, sh_insel[2] ? chan_b : chan_a});
            end
            if (reg_wr && reg_addr == 12'h331) begin
                sh_insel = reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int key;
        int f;
        logic cx;
        logic [7:0] ctl, ins;
        void'($urandom(32'h30EE));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h330, 8'h00, "ctrl_reset");
        rd(12'h331, 8'h05, "insel_reset");
        rd(12'h332, 8'h00, "unmapped");
        check("stage_reset", stage_enable, 9'h003);
        check("factor_reset", decim_factor, 6'h04);
        for (int k = 0; k < 256; k++) begin
            ctl = 8'($urandom);
            ctl[3] = k[4];
            ctl[2:0] = k[7:5];
            ins = 8'($urandom);
            ins[7:4] = k[3:0];
            wr(12'h330, ctl);
            wr(12'h331, ins);
            @(posedge sys_clk);
            #1;
            key = ctl[2:0] == 3'h7 ? 8 + int'(ins[7:4]) : int'(ctl[2:0]);
            f = FC_TAB[key];
            cx = key inside {15, 16, 17};
            check("stage", stage_enable, ST_TAB[key]);
            check("factor", decim_factor, cx ? f : f >> ctl[3]);
            check("invalid", decim_invalid, f == 0 || (cx && ctl[3]));
            check("mixer", mixer_complex, ctl[7]);
            check("gain", gain_double, ctl[6]);
            check("if_mode", if_mode, ctl[5:4]);
            check("real_out", real_output, ctl[3]);
            rd(12'h330, ctl, "ctrl_back");
            rd(12'h331, ins & 8'hF5, "insel_back");
        end
        @(posedge sys_clk);
        slow <= 1'b0;
        stall <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check("ready_full", sample_ready, 1'b0);
        check("valid_held", path_valid, 1'b1);
        @(posedge sys_clk);
        stall <= 1'b0;
        run <= 1'b0;
        repeat (30) @(posedge sys_clk);
        #1;
        check("drained", path_valid, 1'b0);
        check("queue_empty", q.size(), 0);
        @(posedge sys_clk);
        run <= 1'b1;
        wr(12'h330, 8'hFF);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h330, 8'h00, "ctrl_rereset");
        summarize();
    end

    initial begin
        #100000;
        bad_count++;
        summarize();
    end
endmodule : test_ddcc_decode
